// [rtl/anm_pkg.sv]
// Package for the negotiation restart and progress monitor block
package anm_pkg;

    // Register word offsets (byte addresses)
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] BASIC_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] FAST_STATUS_OFFSET = 8'h44;
    localparam logic [7:0] MODE_OFFSET = 8'h08;

    // Control register fields
    localparam int CTRL_RESTART_BIT = 9;
    localparam int CTRL_ENABLE_BIT = 12;
    localparam int CTRL_SOFT_RESET_BIT = 15;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    // Basic status fields
    localparam int BASIC_LINK_BIT = 2;
    localparam int BASIC_DONE_BIT = 5;

    // Fast status fields
    localparam int FAST_RATE_BIT = 15;
    localparam int FAST_DUPLEX_BIT = 14;
    localparam int FAST_PROG_HI = 13;
    localparam int FAST_PROG_LO = 11;
    localparam int FAST_DONE_BIT = 4;
    localparam int FAST_LINK_BIT = 0;

    // Mode register: bit 0 selects hardware mode
    localparam int MODE_HW_BIT = 0;
    localparam logic MODE_HW_RESET = 1'b0;

    // Progress codes
    localparam logic [3:0] PROG_IDLE = 4'h0;
    localparam logic [3:0] PROG_MAX_STEP = 4'h8;
    localparam logic [3:0] PROG_DONE = 4'hf;

    // Negotiation time budget
    localparam int NEG_TIME_MS = 500;
    localparam int CLK_MHZ = 125;
    localparam int NEG_CYCLES = NEG_TIME_MS * 1000 * CLK_MHZ;
    localparam int STEP_CYCLES_DEFAULT = 1000;

    // Status inputs from arbitration datapath
    typedef struct packed {
        logic rate100;
        logic fullDuplex;
        logic linkUp;
    } anm_link_type;

endpackage : anm_pkg

// [rtl/anm_restart_monitor.sv]
// Negotiation restart control and progress monitor with Wishbone slave
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module anm_restart_monitor #(
    parameter int STEP_CYCLES = anm_pkg::STEP_CYCLES_DEFAULT,
    parameter int NEG_LIMIT = anm_pkg::NEG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic negotiationSelectPin,
    input wire logic partnerResponds,
    input wire anm_pkg::anm_link_type linkIn,
    output logic negotiationDone,
    output logic [3:0] arbState
);

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} anm_phase_type;

    logic [2:0] pinSync;
    logic pinLevel;
    logic pinSeenLow;
    logic enable;
    logic hwMode;
    logic restartBit;
    logic enSeenLow;
    logic [3:0] progLatch;
    logic [31:0] stepCount;
    logic [31:0] negCount;
    logic linkSeen;
    anm_phase_type phase;
    logic ack;
    logic [31:0] rdData;

    logic next_pinLevel;
    logic next_pinSeenLow;
    logic next_enable;
    logic next_hwMode;
    logic next_restartBit;
    logic next_enSeenLow;
    logic [3:0] next_progLatch;
    logic [31:0] next_stepCount;
    logic [31:0] next_negCount;
    logic next_linkSeen;
    anm_phase_type next_phase;
    logic [3:0] next_arbState;
    logic next_done;
    logic next_ack;
    logic [31:0] next_rdData;

    logic access;
    logic wrCtrl;
    logic wrMode;
    logic fastRead;
    logic softReset;
    logic anyReset;
    logic restart;
    logic pinToggle;
    logic enToggle;
    logic linkFail;
    logic [31:0] basicWord;
    logic [31:0] fastWord;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    assign access = wb_cyc_i && wb_stb_i && !ack;
    assign wrCtrl = access && wb_we_i && hit(wb_adr_i, anm_pkg::CTRL_OFFSET) && wb_sel_i[1];
    assign wrMode = access && wb_we_i && hit(wb_adr_i, anm_pkg::MODE_OFFSET) && wb_sel_i[0];
    assign fastRead = access && !wb_we_i && hit(wb_adr_i, anm_pkg::FAST_STATUS_OFFSET);
    assign softReset = wrCtrl && wb_dat_i[anm_pkg::CTRL_SOFT_RESET_BIT];
    assign anyReset = rst || softReset;

    // Toggle detection: a low seen, then high again on the source that hwMode selects
    assign pinToggle = hwMode && pinSeenLow && pinLevel;
    assign enToggle = !hwMode && enSeenLow && enable;
    assign linkFail = linkSeen && !linkIn.linkUp;
    assign restart = restartBit || pinToggle || enToggle || linkFail;

    always_comb begin
        next_pinLevel = pinLevel;
        if (pinSync[2] == pinSync[1]) begin
            next_pinLevel = pinSync[2];
        end
        next_pinSeenLow = pinSeenLow;
        if (!pinLevel) begin
            next_pinSeenLow = 1'b1;
        end else if (pinSeenLow) begin
            next_pinSeenLow = 1'b0;
        end
        next_enable = enable;
        next_restartBit = 1'b0;
        next_hwMode = hwMode;
        if (wrCtrl) begin
            next_enable = wb_dat_i[anm_pkg::CTRL_ENABLE_BIT];
            next_restartBit = wb_dat_i[anm_pkg::CTRL_RESTART_BIT];
        end
        if (wrMode) begin
            next_hwMode = wb_dat_i[anm_pkg::MODE_HW_BIT];
        end
        next_enSeenLow = enSeenLow;
        if (!enable) begin
            next_enSeenLow = 1'b1;
        end else if (enSeenLow) begin
            next_enSeenLow = 1'b0;
        end
    end

    wire logic active = hwMode ? pinLevel : enable;

    always_comb begin
        next_phase = phase;
        next_arbState = arbState;
        next_stepCount = stepCount;
        next_negCount = negCount;
        next_linkSeen = linkSeen;
        if (restart || !active) begin
            next_phase = ST_IDLE;
            next_arbState = anm_pkg::PROG_IDLE;
            next_stepCount = '0;
            next_negCount = '0;
            next_linkSeen = 1'b0;
        end else begin
            unique case (phase)
                ST_IDLE: begin
                    next_phase = ST_RUN;
                end
                ST_RUN: begin
                    next_negCount = negCount + 32'd1;
                    next_stepCount = stepCount + 32'd1;
                    // Steps stand in for the arbitration, bounded by the budget
                    if (stepCount >= 32'(STEP_CYCLES - 1)
                            || negCount >= 32'(NEG_LIMIT - 1)) begin
                        next_stepCount = '0;
                        if (arbState == anm_pkg::PROG_MAX_STEP
                                || negCount >= 32'(NEG_LIMIT - 1)
                                || (arbState >= 4'h3 && !partnerResponds)) begin
                            next_phase = ST_DONE;
                            next_arbState = anm_pkg::PROG_DONE;
                            next_linkSeen = linkIn.linkUp;
                        end else begin
                            next_arbState = arbState + 4'h1;
                        end
                    end
                end
                ST_DONE: begin
                    // A held link reads back as complete with zero progress bits
                    if (linkIn.linkUp) begin
                        next_linkSeen = 1'b1;
                        next_arbState = anm_pkg::PROG_MAX_STEP;
                    end
                end
                default: begin
                    next_phase = ST_IDLE;
                end
            endcase
        end
        next_done = (next_phase == ST_DONE);
    end

    always_comb begin
        next_progLatch = progLatch;
        if (fastRead) begin
            next_progLatch = arbState;
        end else if (progLatch != anm_pkg::PROG_DONE && arbState > progLatch) begin
            next_progLatch = arbState;
        end
    end

    // Fast status word; progress bits drop to zero after the completion read while the link is held
    always_comb begin
        fastWord = '0;
        fastWord[anm_pkg::FAST_RATE_BIT] = linkIn.rate100;
        fastWord[anm_pkg::FAST_DUPLEX_BIT] = linkIn.fullDuplex;
        fastWord[anm_pkg::FAST_LINK_BIT] = linkIn.linkUp;
        fastWord[anm_pkg::FAST_PROG_HI:anm_pkg::FAST_PROG_LO] =
            (progLatch == anm_pkg::PROG_DONE) ? 3'b111 : progLatch[2:0];
        fastWord[anm_pkg::FAST_DONE_BIT] = negotiationDone
            || (progLatch == anm_pkg::PROG_DONE) || progLatch[3];
        basicWord = '0;
        basicWord[anm_pkg::BASIC_DONE_BIT] = negotiationDone;
        basicWord[anm_pkg::BASIC_LINK_BIT] = linkIn.linkUp;
    end

    always_comb begin
        next_ack = access;
        next_rdData = '0;
        if (hit(wb_adr_i, anm_pkg::CTRL_OFFSET)) begin
            next_rdData[anm_pkg::CTRL_ENABLE_BIT] = enable;
            next_rdData[anm_pkg::CTRL_RESTART_BIT] = restartBit;
        end else if (hit(wb_adr_i, anm_pkg::BASIC_STATUS_OFFSET)) begin
            next_rdData = basicWord;
        end else if (hit(wb_adr_i, anm_pkg::FAST_STATUS_OFFSET)) begin
            next_rdData = fastWord;
        end else if (hit(wb_adr_i, anm_pkg::MODE_OFFSET)) begin
            next_rdData[anm_pkg::MODE_HW_BIT] = hwMode;
        end
    end

    // Synchroniser stages carry no reset; pinLevel masks their start-up state
    always_ff @(posedge ref_clk) begin
        pinSync <= {pinSync[1:0], negotiationSelectPin};
    end

    // Bus answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack <= 1'b0;
            rdData <= '0;
        end else begin
            ack <= next_ack;
            rdData <= next_rdData;
        end
    end

    // Pin level starts high so no false toggle follows reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinLevel <= 1'b1;
            pinSeenLow <= 1'b0;
        end else begin
            pinLevel <= next_pinLevel;
            pinSeenLow <= next_pinSeenLow;
        end
    end

    // Control bits; a soft reset keeps the mode so a pin-strapped part stays put
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable <= anm_pkg::CTRL_ENABLE_RESET;
            hwMode <= anm_pkg::MODE_HW_RESET;
            restartBit <= 1'b0;
            enSeenLow <= 1'b0;
        end else begin
            enable <= softReset ? anm_pkg::CTRL_ENABLE_RESET : next_enable;
            hwMode <= next_hwMode;
            restartBit <= softReset ? 1'b0 : next_restartBit;
            enSeenLow <= softReset ? 1'b0 : next_enSeenLow;
        end
    end

    // Arbitration stand-in
    always_ff @(posedge ref_clk) begin
        if (anyReset) begin
            phase <= ST_IDLE;
            arbState <= anm_pkg::PROG_IDLE;
            stepCount <= '0;
            negCount <= '0;
            linkSeen <= 1'b0;
            negotiationDone <= 1'b0;
        end else begin
            phase <= next_phase;
            arbState <= next_arbState;
            stepCount <= next_stepCount;
            negCount <= next_negCount;
            linkSeen <= next_linkSeen;
            negotiationDone <= next_done;
        end
    end

    // Progress latch: a reset clears it, a fast status read reloads it from arbState, a restart leaves it alone
    always_ff @(posedge ref_clk) begin
        if (anyReset) begin
            progLatch <= anm_pkg::PROG_IDLE;
        end else begin
            progLatch <= next_progLatch;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdData;
    assign wb_err_o = 1'b0;

endmodule : anm_restart_monitor

// [testbench/anm_link_partner.sv]
// Line-side partner: negotiates and holds link once done
`timescale 1ns/1ps
module anm_link_partner (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic negotiationDone,
    input wire logic dropLink,
    output logic partnerResponds,
    output anm_pkg::anm_link_type linkIn
);
    assign partnerResponds = 1'b1;
    // Link follows completion a cycle late, like a real link monitor
    always_ff @(posedge ref_clk) begin
        linkIn <= rst ? 3'b110 : {2'b11, negotiationDone && !dropLink};
    end
endmodule : anm_link_partner

// [testbench/anm_restart_monitor_sva.sv]
// Port-level assertions for the restart monitor
`timescale 1ns/1ps
module anm_restart_monitor_sva #(
    parameter int STEP_CYCLES = anm_pkg::STEP_CYCLES_DEFAULT,
    parameter int NEG_LIMIT = anm_pkg::NEG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire anm_pkg::anm_link_type linkIn,
    input wire logic negotiationDone,
    input wire logic [3:0] arbState
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_restartBit;
        s_req ##0 (wb_we_i && wb_adr_i == anm_pkg::CTRL_OFFSET && wb_sel_i[1] && wb_dat_i[9]);
    endsequence
    property p_ack; s_req |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_err; !wb_err_o; endproperty
    a_err: assert property (p_err) else $error("err raised");
    // Reset attempts must still be judged while reset is high
    property p_rst; disable iff (1'b0) rst |=> arbState == 4'h0 && !negotiationDone; endproperty
    a_rst: assert property (p_rst) else $error("reset not idle");
    property p_codes; arbState <= 4'h8 || arbState == 4'hf; endproperty
    a_codes: assert property (p_codes) else $error("bad code");
    property p_start; $fell(rst) |-> ##[1:40] arbState != 4'h0; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_finish; $fell(rst) |-> ##[1:300] negotiationDone; endproperty
    a_finish: assert property (p_finish) else $error("no finish");
    property p_rbit; s_restartBit |=> ##[0:4] arbState == anm_pkg::PROG_IDLE; endproperty
    a_rbit: assert property (p_rbit) else $error("no restart");
    property p_fail; (negotiationDone && linkIn.linkUp) ##1 !linkIn.linkUp |-> ##[0:4] !negotiationDone; endproperty
    a_fail: assert property (p_fail) else $error("no link restart");
endmodule : anm_restart_monitor_sva
bind anm_restart_monitor anm_restart_monitor_sva #(.STEP_CYCLES(STEP_CYCLES), .NEG_LIMIT(NEG_LIMIT))
    u_sva (.ref_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_err_o, .linkIn, .negotiationDone, .arbState);

// [testbench/anm_restart_monitor_test.sv]
// Self-checking bench for the restart monitor
`timescale 1ns/1ps
module anm_restart_monitor_test;
    logic ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, err, pin = 1, resp, done, drop = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q;
    logic [3:0] sel = 4'h0, arb;
    anm_pkg::anm_link_type link;
    int failCount = 0, checkCount = 0, cycles = 0;
    always #4 ref_clk = ~ref_clk;
    anm_restart_monitor #(.STEP_CYCLES(4), .NEG_LIMIT(64)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err),
        .negotiationSelectPin(pin), .partnerResponds(resp), .linkIn(link),
        .negotiationDone(done), .arbState(arb));
    anm_link_partner u_lp (.ref_clk(ref_clk), .rst(rst), .negotiationDone(done),
        .dropLink(drop), .partnerResponds(resp), .linkIn(link));
    task automatic endSim;
        $display("checks %0d mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : endSim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checkCount++;
        if (g !== e) begin
            failCount++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Held request is released at the edge that samples ack, or after 50 edges without one
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) failCount++;
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task automatic waitDone;
        int n;
        n = 0;
        do begin
            wb(0, 8'h04, 0, 4'hf);
            n++;
        end while (q[5:2] !== 4'h9 && n < 300);
        chk(q & 32'h24, 32'h24);
    endtask : waitDone
    // First read shows the code held across the restart
    task automatic restarted(input logic [31:0] first);
        repeat (6) @(posedge ref_clk);
        wb(0, 8'h44, 0, 4'hf);
        chk(q & 32'h3810, first);
        wb(0, 8'h44, 0, 4'hf);
        chk(q & 32'h10, 32'h0);
    endtask : restarted
    task automatic tSoftReset;
        wb(1, 8'h00, 32'h9000, 4'h3);
        wb(0, 8'h44, 0, 4'hf);
        chk(q & 32'h3810, 32'h0);
        wb(0, 8'h80, 0, 4'hf);
        chk(q, 32'h0);
    endtask : tSoftReset
    task automatic tComplete;
        waitDone();
        wb(0, 8'h44, 0, 4'hf);
        chk(q & 32'hf811, 32'hf811);
        wb(0, 8'h44, 0, 4'hf);
        chk(q & 32'hf811, 32'hc011);
    endtask : tComplete
    task automatic tRestartBit;
        waitDone();
        wb(1, 8'h00, 32'h1200, 4'h3);
        wb(0, 8'h00, 0, 4'hf);
        chk(q & 32'h1200, 32'h1000);
        restarted(32'h0010);
    endtask : tRestartBit
    task automatic tToggle;
        waitDone();
        wb(1, 8'h00, 32'h0000, 4'h3);
        wb(1, 8'h00, 32'h1000, 4'h3);
        restarted(32'h3810);
    endtask : tToggle
    task automatic tPin;
        waitDone();
        wb(1, 8'h08, 32'h1, 4'h1);
        @(posedge ref_clk) pin <= 0;
        repeat (8) @(posedge ref_clk);
        pin <= 1;
        restarted(32'h3810);
    endtask : tPin
    task automatic tLink;
        waitDone();
        @(posedge ref_clk) drop <= 1;
        repeat (4) @(posedge ref_clk);
        drop <= 0;
        restarted(32'h3810);
    endtask : tLink
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            endSim();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 0;
        tSoftReset();
        tComplete();
        tRestartBit();
        tToggle();
        tPin();
        tLink();
        endSim();
    end
endmodule : anm_restart_monitor_test
